// ### design/pcwl_write_lock.sv
// Command write-lock mask and unlock code guard for a PMBus power converter.
// Assumes a PMBus front end presenting one decoded command per request, an NVM
// image presented with a boot pulse after power-on reset, and a level telling
// whether the standard write-protect setting forbids the command being asked.
//
// Functional notes
// RULE1: Lock mask lives at command FBh, word write and word read.
// RULE2: Mask loads from NVM at boot; one copy shared by all phases.
// RULE3: Each mask bit alone makes its command group read-only.
// RULE4: Bit 15 guards the mask and unlock code; saved it locks forever.
// RULE5: Bit 14 alone guards the standard write-protect command.
// RULE6: Bit 13 guards trim, scale loop and current calibration commands.
// RULE7: Bit 12 guards output mode and output setpoint commands.
// RULE8: Bit 11 guards output limits and output fault limits and responses.
// RULE9: Bit 10 guards warning limits and the alert mask.
// RULE10: Bit 9 guards current and temperature faults plus fault simulation.
// RULE11: Bit 8 guards margins and transition rate; bit 7 guards run control.
// RULE12: Bit 6 guards the switching, compensation and other setup commands.
// RULE13: Bit 5 guards input voltage limits and input fault response.
// RULE14: Bit 4 guards turn-on and turn-off sequencing and input thresholds.
// RULE15: Bit 3 guards the identity information commands.
// RULE16: Bit 2 guards pin detect override and bus address.
// RULE17: Bit 1 guards the unlock code; with nonzero code it locks forever.
// RULE18: Bit 1 with a zero unlock code refuses any new code.
// RULE19: A nonzero unlock code guards the mask until the right code arrives.
// RULE20: Bit 0 guards the NVM save command, also after reset and restore.
// RULE21: A nonzero boot code guards mask and save until matched exactly.
// RULE22: Three misses in a row bar all code writes until power-on reset.
// RULE23: Guarded writes are dropped, state kept, and flagged invalid.
`timescale 1ns/1ps
module pcwl_write_lock #(
    parameter int KEY_TRIES = pcwl_pkg::KEY_TRIES_DEFAULT
) (
    input wire logic clock, // 250 MHz logic clock
    input wire logic nrst, // Power-on reset, asynchronous, active low
    input wire pcwl_pkg::pcwl_req_t req, // Decoded PMBus command request
    input wire logic stdWpBlock, // Standard write-protect forbids req.code
    input wire logic bootLoad, // One-cycle pulse: NVM image valid at boot
    input wire logic restoreLoad, // One-cycle pulse: NVM restore of the mask
    input wire pcwl_pkg::pcwl_nvm_t nvmImage, // Stored mask and unlock code
    output pcwl_pkg::pcwl_resp_t resp, // Answer one cycle after each request
    output logic nvmSave, // One-cycle pulse: write nvmSaveImage to NVM
    output pcwl_pkg::pcwl_nvm_t nvmSaveImage, // Image to be stored
    output logic [pcwl_pkg::DATA_WIDTH-1:0] lockMask, // Active lock mask
    output logic keyOpen // Mask and save are not held by the unlock code
);
    import pcwl_pkg::*;

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if ((KEY_TRIES < 1) || (KEY_TRIES > 3)) begin : g_bad_tries
        $error("KEY_TRIES must be 1 to 3");
    end

    localparam logic [1:0] TRY_LIMIT = 2'(KEY_TRIES);

    logic [DATA_WIDTH-1:0] groupSel;
    logic [DATA_WIDTH-1:0] groupHit;
    logic [DATA_WIDTH-1:0] bootKey;
    logic [DATA_WIDTH-1:0] activeKey;
    logic [DATA_WIDTH-1:0] readValue;
    logic [1:0] keyFails;
    pcwl_key_state_t keyState;
    logic bootDone;
    logic isMaskCmd;
    logic isKeyCmd;
    logic isStoreCmd;
    logic isStdWpCmd;
    logic keyGuard;
    logic writeBlocked;
    logic keyMiss;
    logic writeInvalid;
    logic isWrite;
    logic maskWrite;
    logic keyWrite;
    logic storeWrite;

    // ------------------------------------------------------------------
    // Command group lookup
    // ------------------------------------------------------------------
    pcwl_group_decode u_decode (
        .code(req.code),
        .groupSel(groupSel)
    );

    // RULE3 independent group bits
    for (genvar i = 0; i < DATA_WIDTH; i++) begin : g_hit
        assign groupHit[i] = groupSel[i] & lockMask[i];
    end

    // ------------------------------------------------------------------
    // Write permission
    // ------------------------------------------------------------------
    always_comb begin
        isWrite = req.valid & req.write;
        isMaskCmd = req.code == CMD_LOCK_MASK;
        isKeyCmd = req.code == CMD_UNLOCK_CODE;
        isStoreCmd = req.code == CMD_STORE_USER_ALL;
        isStdWpCmd = req.code == CMD_WRITE_PROTECT;
        // RULE19 code guards mask
        keyGuard = keyState != KEY_OPEN;
        writeBlocked = 1'b0;
        // RULE23 check on receipt
        if (!bootDone) begin
            writeBlocked = 1'b1;
        end else if (isMaskCmd) begin
            // RULE4 self lock
            writeBlocked = lockMask[BIT_SELF_LOCK] | keyGuard;
        end else if (isKeyCmd) begin
            // RULE17 key lock bit
            writeBlocked = lockMask[BIT_SELF_LOCK] | lockMask[BIT_UNLOCK_KEY] | (keyState == KEY_BARRED)
                | stdWpBlock;
        end else if (isStdWpCmd) begin
            // RULE5 only bit 14
            writeBlocked = lockMask[BIT_STD_GUARD];
        end else if (isStoreCmd) begin
            // RULE20 save guard
            writeBlocked = lockMask[BIT_NVM_SAVE] | keyGuard | stdWpBlock;
        end else begin
            // RULE6 to RULE16 group locks
            writeBlocked = (|groupHit) | stdWpBlock;
        end
        // RULE21 exact boot code
        keyMiss = isKeyCmd & !writeBlocked & (keyState == KEY_LOCKED) & (req.data != bootKey);
        writeInvalid = writeBlocked | keyMiss;
        maskWrite = isWrite & isMaskCmd & !writeInvalid;
        keyWrite = isWrite & isKeyCmd & !writeBlocked;
        storeWrite = isWrite & isStoreCmd & !writeInvalid;
    end

    // ------------------------------------------------------------------
    // Lock mask register
    // ------------------------------------------------------------------
    // RULE2 boot and restore load
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lockMask <= MASK_RESET;
        end else if (bootLoad | restoreLoad) begin
            lockMask <= nvmImage.mask;
        end else if (maskWrite) begin
            lockMask <= req.data;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bootDone <= 1'b0;
        end else if (bootLoad) begin
            bootDone <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Unlock code
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bootKey <= KEY_ZERO;
        end else if (bootLoad) begin
            bootKey <= nvmImage.key;
        end
    end

    // RULE18 new code while open
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            activeKey <= KEY_ZERO;
        end else if (bootLoad) begin
            activeKey <= nvmImage.key;
        end else if (keyWrite && keyState == KEY_OPEN) begin
            activeKey <= req.data;
        end
    end

    // RULE22 miss counting
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            keyState <= KEY_OPEN;
            keyFails <= 2'h0;
        end else if (bootLoad) begin
            keyState <= (nvmImage.key != KEY_ZERO) ? KEY_LOCKED : KEY_OPEN;
            keyFails <= 2'h0;
        end else if (keyWrite) begin
            case (keyState)
                KEY_LOCKED: begin
                    if (!keyMiss) begin
                        keyState <= KEY_OPEN;
                        keyFails <= 2'h0;
                    end else if (keyFails + 2'h1 >= TRY_LIMIT) begin
                        keyState <= KEY_BARRED;
                        keyFails <= keyFails + 2'h1;
                    end else begin
                        keyFails <= keyFails + 2'h1;
                    end
                end
                default: begin
                    keyState <= keyState;
                end
            endcase
        end
    end

    assign keyOpen = keyState == KEY_OPEN;

    // ------------------------------------------------------------------
    // Read data and answers
    // ------------------------------------------------------------------
    always_comb begin
        readValue = '0;
        if (isMaskCmd) begin
            // RULE1 mask readback
            readValue = lockMask;
        end else if (isKeyCmd) begin
            if (keyState == KEY_OPEN) begin
                readValue = KEY_RD_OPEN;
            end else if (keyState == KEY_BARRED) begin
                readValue = KEY_RD_BARRED;
            end else if (keyFails == 2'h0) begin
                readValue = KEY_RD_FAIL0;
            end else if (keyFails == 2'h1) begin
                readValue = KEY_RD_FAIL1;
            end else begin
                readValue = KEY_RD_FAIL2;
            end
        end
    end

    // RULE23 flag invalid writes
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            resp <= '0;
        end else begin
            resp.done <= req.valid;
            resp.accepted <= isWrite & !writeInvalid;
            resp.invalid <= isWrite & writeInvalid;
            resp.code <= req.code;
            resp.rdata <= (req.valid && !req.write) ? readValue : '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            nvmSave <= 1'b0;
            nvmSaveImage <= '0;
        end else begin
            nvmSave <= storeWrite;
            if (storeWrite) begin
                nvmSaveImage <= {lockMask, activeKey};
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence maskWriteSeq;
        bootDone && isWrite && isMaskCmd;
    endsequence

    sequence keyWriteSeq;
        bootDone && isWrite && isKeyCmd;
    endsequence

    sequence storeWriteSeq;
        bootDone && isWrite && isStoreCmd;
    endsequence

    answer_timing_a: assert property (req.valid |=> resp.done ##1 !resp.done || $past(req.valid)) // RULE1
        else $error("request not answered in one cycle");

    boot_load_a: assert property (bootLoad |=> lockMask == $past(nvmImage.mask)) // RULE2
        else $error("mask not loaded from NVM image");

    self_lock_a: assert property ((maskWriteSeq and lockMask[BIT_SELF_LOCK]) // RULE4
        |=> resp.invalid && lockMask == $past(lockMask) || $past(restoreLoad))
        else $error("mask written while self lock set");

    std_guard_a: assert property (bootDone && isWrite && isStdWpCmd // RULE5
        |=> resp.accepted != $past(lockMask[BIT_STD_GUARD]))
        else $error("standard write-protect guard wrong");

    group_lock_a: assert property (bootDone && isWrite && !isMaskCmd && !isKeyCmd && !isStoreCmd // RULE3
        && !isStdWpCmd && (|(groupSel & lockMask)) |=> resp.invalid && !resp.accepted)
        else $error("locked command group accepted");

    key_guard_a: assert property ((maskWriteSeq and keyState != KEY_OPEN) ##1 1'b1 // RULE19
        |-> resp.invalid)
        else $error("mask written while unlock code holds");

    key_zero_refuse_a: assert property ((keyWriteSeq and lockMask[BIT_UNLOCK_KEY] && activeKey == KEY_ZERO) // RULE18
        |=> resp.invalid && activeKey == KEY_ZERO)
        else $error("new unlock code accepted with key lock set");

    key_bar_a: assert property ((keyWriteSeq and keyState == KEY_LOCKED && keyMiss // RULE22
        && keyFails == TRY_LIMIT - 2'h1) |=> keyState == KEY_BARRED ##1 keyState == KEY_BARRED || $past(bootLoad))
        else $error("unlock code not barred after last miss");

    key_match_a: assert property ((keyWriteSeq and keyState == KEY_LOCKED && !writeBlocked // RULE21
        && req.data == bootKey) |=> keyOpen && keyFails == 2'h0)
        else $error("matching unlock code did not open");

    store_lock_a: assert property ((storeWriteSeq and lockMask[BIT_NVM_SAVE]) // RULE20
        |=> resp.invalid && !nvmSave)
        else $error("NVM save accepted while locked");

    key_lock_bit_a: assert property ((keyWriteSeq and lockMask[BIT_UNLOCK_KEY]) // RULE17
        |=> resp.invalid && (activeKey == $past(activeKey) || $past(bootLoad)))
        else $error("unlock code written under key lock");

    key_barred_a: assert property ((keyWriteSeq and keyState == KEY_BARRED) // RULE22
        |=> resp.invalid && !resp.accepted)
        else $error("unlock code write taken after bar");

    boot_gate_a: assert property (!bootDone && isWrite // RULE23
        |=> resp.invalid && !resp.accepted)
        else $error("write taken before boot load");

    group_guard_a: assert property (bootDone && isWrite && (|groupSel) && stdWpBlock // RULE6 to RULE16
        |=> resp.invalid && !resp.accepted)
        else $error("write-protected command accepted");

    save_image_a: assert property ((storeWriteSeq and keyOpen && !lockMask[BIT_NVM_SAVE] && !stdWpBlock) // RULE2
        |=> nvmSave && resp.accepted && nvmSaveImage.mask == $past(lockMask))
        else $error("NVM save image wrong");

    mask_write_a: assert property ((maskWriteSeq and keyOpen && !lockMask[BIT_SELF_LOCK] && !restoreLoad) // RULE1
        |=> resp.accepted && (lockMask == $past(req.data) || $past(bootLoad)))
        else $error("open mask write not stored");

    mask_read_a: assert property (req.valid && !req.write && isMaskCmd // RULE1
        |=> resp.done && !resp.accepted && resp.rdata == $past(lockMask))
        else $error("mask readback wrong");

    keep_state_a: assert property (isWrite && writeInvalid && !bootLoad && !restoreLoad // RULE23
        |=> lockMask == $past(lockMask) && activeKey == $past(activeKey) && !nvmSave)
        else $error("refused write changed state");

endmodule

// ### design/pcwl_pkg.sv
// Shared constants and types for the PMBus command write-lock block.
// Assumes a PMBus front end that decodes transactions into one command per request.
package pcwl_pkg;

    // ------------------------------------------------------------------
    // Widths and command codes
    // ------------------------------------------------------------------
    localparam int CMD_WIDTH = 8;
    localparam int DATA_WIDTH = 16;
    localparam logic [7:0] CMD_WRITE_PROTECT = 8'h10;
    localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
    localparam logic [7:0] CMD_UNLOCK_CODE = 8'hFA;
    localparam logic [7:0] CMD_LOCK_MASK = 8'hFB;

    // ------------------------------------------------------------------
    // Lock mask bit positions
    // ------------------------------------------------------------------
    localparam int BIT_SELF_LOCK = 15;
    localparam int BIT_STD_GUARD = 14;
    localparam int BIT_CALIBRATION = 13;
    localparam int BIT_SETPOINT = 12;
    localparam int BIT_OUT_FAULT = 11;
    localparam int BIT_WARN_LIMIT = 10;
    localparam int BIT_CUR_TEMP = 9;
    localparam int BIT_OUT_STEP = 8;
    localparam int BIT_RUN_CONTROL = 7;
    localparam int BIT_SETUP = 6;
    localparam int BIT_IN_LIMIT = 5;
    localparam int BIT_POWER_ORDER = 4;
    localparam int BIT_IDENTITY = 3;
    localparam int BIT_ADDR_STRAP = 2;
    localparam int BIT_UNLOCK_KEY = 1;
    localparam int BIT_NVM_SAVE = 0;

    // ------------------------------------------------------------------
    // Reset values and unlock code readback words
    // ------------------------------------------------------------------
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] KEY_ZERO = 16'h0000;
    localparam logic [15:0] KEY_RD_OPEN = 16'h0000;
    localparam logic [15:0] KEY_RD_FAIL0 = 16'h000F;
    localparam logic [15:0] KEY_RD_FAIL1 = 16'h001F;
    localparam logic [15:0] KEY_RD_FAIL2 = 16'h002F;
    localparam logic [15:0] KEY_RD_BARRED = 16'h00FF;
    localparam int KEY_TRIES_DEFAULT = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {KEY_OPEN, KEY_LOCKED, KEY_BARRED} pcwl_key_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [CMD_WIDTH-1:0] code;
        logic [DATA_WIDTH-1:0] data;
    } pcwl_req_t;

    typedef struct packed {
        logic done;
        logic accepted;
        logic invalid;
        logic [CMD_WIDTH-1:0] code;
        logic [DATA_WIDTH-1:0] rdata;
    } pcwl_resp_t;

    typedef struct packed {
        logic [DATA_WIDTH-1:0] mask;
        logic [DATA_WIDTH-1:0] key;
    } pcwl_nvm_t;

endpackage

// ### design/pcwl_group_decode.sv
// Maps a PMBus command code onto the lock mask bits that guard it.
// Assumes manufacturer-specific codes are given by parameter; setup commands in one range.
`timescale 1ns/1ps
module pcwl_group_decode #(
    parameter logic [7:0] SETUP_FIRST_CODE = 8'hD0,
    parameter logic [7:0] SETUP_LAST_CODE = 8'hD7,
    parameter logic [7:0] SIM_FAULTS_CODE = 8'hD8,
    parameter logic [7:0] PIN_OVERRIDE_CODE = 8'hEE,
    parameter logic [7:0] BUS_ADDRESS_CODE = 8'hEF
) (
    input wire logic [pcwl_pkg::CMD_WIDTH-1:0] code, // Command code of the request
    output logic [pcwl_pkg::DATA_WIDTH-1:0] groupSel // One bit per guarding mask bit
);
    import pcwl_pkg::*;

    // ------------------------------------------------------------------
    // Standard command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] C_OPERATION = 8'h01, C_ON_OFF_CFG = 8'h02, C_ALERT_MASK = 8'h1B;
    localparam logic [7:0] C_OUT_MODE = 8'h20, C_OUT_COMMAND = 8'h21, C_OUT_TRIM = 8'h22;
    localparam logic [7:0] C_OUT_MAX = 8'h24, C_MARGIN_HIGH = 8'h25, C_MARGIN_LOW = 8'h26;
    localparam logic [7:0] C_TRANS_RATE = 8'h27, C_SCALE_LOOP = 8'h29, C_OUT_MIN = 8'h2B;
    localparam logic [7:0] C_FREQ_SWITCH = 8'h33, C_IN_ON = 8'h35, C_IN_OFF = 8'h36, C_INTERLEAVE = 8'h37;
    localparam logic [7:0] C_CAL_GAIN = 8'h38, C_CAL_OFFSET = 8'h39;
    localparam logic [7:0] C_OUT_OV_FLT = 8'h40, C_OUT_OV_RSP = 8'h41, C_OUT_OV_WRN = 8'h42;
    localparam logic [7:0] C_OUT_UV_WRN = 8'h43, C_OUT_UV_FLT = 8'h44, C_OUT_UV_RSP = 8'h45;
    localparam logic [7:0] C_OC_FLT = 8'h46, C_OC_RSP = 8'h47, C_OC_WRN = 8'h4A;
    localparam logic [7:0] C_OT_FLT = 8'h4F, C_OT_RSP = 8'h50, C_OT_WRN = 8'h51;
    localparam logic [7:0] C_IN_OV_FLT = 8'h55, C_IN_OV_RSP = 8'h56, C_IN_OV_WRN = 8'h57, C_IN_UV_WRN = 8'h58;
    localparam logic [7:0] C_TON_DELAY = 8'h60, C_TON_RISE = 8'h61, C_TON_MAX_FLT = 8'h62, C_TON_MAX_RSP = 8'h63;
    localparam logic [7:0] C_TOFF_DELAY = 8'h64, C_TOFF_FALL = 8'h65;
    localparam logic [7:0] C_MAKER_ID = 8'h99, C_MODEL = 8'h9A, C_REVISION = 8'h9B, C_SERIAL = 8'h9E;

    if (SETUP_FIRST_CODE > SETUP_LAST_CODE) begin : g_bad_range
        $error("setup command range is reversed");
    end

    // ------------------------------------------------------------------
    // Group decode
    // ------------------------------------------------------------------
    always_comb begin
        groupSel = '0;
        case (code)
            // RULE6 calibration group
            C_OUT_TRIM, C_SCALE_LOOP, C_CAL_GAIN, C_CAL_OFFSET: groupSel[BIT_CALIBRATION] = 1'b1;
            // RULE7 setpoint group
            C_OUT_MODE, C_OUT_COMMAND: groupSel[BIT_SETPOINT] = 1'b1;
            // RULE8 output fault group
            C_OUT_MAX, C_OUT_MIN, C_OUT_OV_FLT, C_OUT_OV_RSP, C_OUT_UV_FLT, C_OUT_UV_RSP: begin
                groupSel[BIT_OUT_FAULT] = 1'b1;
            end
            // RULE9 warning group
            C_OUT_OV_WRN, C_OUT_UV_WRN, C_OC_WRN, C_OT_WRN, C_ALERT_MASK: groupSel[BIT_WARN_LIMIT] = 1'b1;
            // RULE10 current temp group
            C_OC_FLT, C_OC_RSP, C_OT_FLT, C_OT_RSP, SIM_FAULTS_CODE: groupSel[BIT_CUR_TEMP] = 1'b1;
            // RULE11 step and run
            C_MARGIN_HIGH, C_MARGIN_LOW, C_TRANS_RATE: groupSel[BIT_OUT_STEP] = 1'b1;
            C_OPERATION: groupSel[BIT_RUN_CONTROL] = 1'b1;
            // RULE12 setup group
            C_FREQ_SWITCH, C_INTERLEAVE: groupSel[BIT_SETUP] = 1'b1;
            // RULE13 input limit group
            C_IN_UV_WRN, C_IN_OV_FLT, C_IN_OV_WRN, C_IN_OV_RSP: groupSel[BIT_IN_LIMIT] = 1'b1;
            // RULE14 sequencing group
            C_TON_DELAY, C_TON_RISE, C_TON_MAX_FLT, C_TON_MAX_RSP, C_TOFF_DELAY, C_TOFF_FALL,
            C_ON_OFF_CFG, C_IN_ON, C_IN_OFF: groupSel[BIT_POWER_ORDER] = 1'b1;
            // RULE15 identity group
            C_MAKER_ID, C_MODEL, C_REVISION, C_SERIAL: groupSel[BIT_IDENTITY] = 1'b1;
            // RULE16 address group
            PIN_OVERRIDE_CODE, BUS_ADDRESS_CODE: groupSel[BIT_ADDR_STRAP] = 1'b1;
            default: groupSel[BIT_SETUP] = (code >= SETUP_FIRST_CODE) && (code <= SETUP_LAST_CODE);
        endcase
    end

endmodule

// ### test/pcwl_host_model.sv
// Host side model of the PMBus configuration master facing the write-lock block.
// Assumes requests are taken at a rising edge and answered one cycle later.
`timescale 1ns/1ps
module pcwl_host_model (
    input wire logic clock, // Logic clock
    input wire pcwl_pkg::pcwl_resp_t resp, // Answer from the device
    output pcwl_pkg::pcwl_req_t req // Command request to the device
);
    import pcwl_pkg::*;

    pcwl_resp_t last;

    initial begin
        req = '0;
        last = '0;
    end

    // ------------------------------------------------------------------
    // Word access
    // ------------------------------------------------------------------
    // whole word transfer
    task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data, input int gap);
        repeat (gap) @(negedge clock);
        @(negedge clock);
        req = {1'b1, wr, code, data};
        @(negedge clock);
        last = resp;
        // Released fields carry inverted values so a stale word never looks fresh.
        req = {1'b0, ~wr, ~code, ~data};
    endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the PMBus command write-lock block.
// Assumes the host model drives all requests; NVM pulses come from here.
`timescale 1ns/1ps
module testbench;
    import pcwl_pkg::*;

    logic clock;
    logic nrst;
    logic stdWpBlock;
    logic bootLoad;
    logic restoreLoad;
    pcwl_nvm_t nvmImage;
    pcwl_req_t req;
    pcwl_resp_t resp;
    logic nvmSave;
    pcwl_nvm_t nvmSaveImage;
    logic [15:0] lockMask;
    logic keyOpen;
    int n_errors = 0;
    int checks_done = 0;
    logic [7:0] grp [13:2] = '{8'h22, 8'h21, 8'h40, 8'h51, 8'h46, 8'h25, 8'h01, 8'h33, 8'h55, 8'h60, 8'h99, 8'hEF};

    pcwl_write_lock #(.KEY_TRIES(3)) u_dut (.clock(clock), .nrst(nrst), .req(req), .stdWpBlock(stdWpBlock),
        .bootLoad(bootLoad), .restoreLoad(restoreLoad), .nvmImage(nvmImage), .resp(resp), .nvmSave(nvmSave),
        .nvmSaveImage(nvmSaveImage), .lockMask(lockMask), .keyOpen(keyOpen));
    pcwl_host_model u_host (.clock(clock), .resp(resp), .req(req));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic acc);
        u_host.access(1'b1, c, d, 0);
        chk({5'h0, u_host.last.code, u_host.last.done, u_host.last.accepted, u_host.last.invalid}, {5'h0, c, 1'b1, acc, ~acc});
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        u_host.access(1'b0, c, 16'h0000, 2);
        chk({15'h0, u_host.last.done}, 16'h0001);
        chk(u_host.last.rdata, e);
    endtask

    task automatic boot(input logic [15:0] m, input logic [15:0] k);
        @(negedge clock);
        nvmImage = {m, k};
        bootLoad = 1'b1;
        @(negedge clock);
        bootLoad = 1'b0;
    endtask

    task automatic results();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (3000) @(posedge clock);
        n_errors++;
        results();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        stdWpBlock = 1'b0;
        bootLoad = 1'b0;
        restoreLoad = 1'b0;
        nvmImage = '0;
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        chk(lockMask, MASK_RESET);
        wr(CMD_LOCK_MASK, 16'h0001, 1'b0);
        chk(lockMask, MASK_RESET);
        boot(16'h0000, KEY_ZERO);
        wr(CMD_LOCK_MASK, 16'h1234, 1'b1);
        rd(CMD_LOCK_MASK, 16'h1234);
        rd(CMD_UNLOCK_CODE, KEY_RD_OPEN);
        for (int b = 13; b >= 2; b--) begin
            wr(CMD_LOCK_MASK, 16'h0001 << b, 1'b1);
            wr(grp[b], 16'h00A5, 1'b0);
            wr(grp[(b == 2) ? 3 : b - 1], 16'h00A5, 1'b1);
        end
        wr(CMD_LOCK_MASK, 16'h0000, 1'b1);
        @(negedge clock);
        stdWpBlock = 1'b1;
        wr(8'h21, 16'h00A5, 1'b0);
        wr(8'hEF, 16'h00A5, 1'b0);
        wr(CMD_WRITE_PROTECT, 16'h0000, 1'b1);
        wr(CMD_LOCK_MASK, 16'h4000, 1'b1);
        @(negedge clock);
        stdWpBlock = 1'b0;
        wr(CMD_WRITE_PROTECT, 16'h0000, 1'b0);
        wr(CMD_LOCK_MASK, 16'h0001, 1'b1);
        wr(CMD_STORE_USER_ALL, 16'h0000, 1'b0);
        chk({15'h0, nvmSave}, 16'h0000);
        wr(CMD_LOCK_MASK, 16'h0002, 1'b1);
        wr(CMD_UNLOCK_CODE, 16'h5555, 1'b0);
        wr(CMD_LOCK_MASK, 16'h0000, 1'b1);
        wr(CMD_UNLOCK_CODE, 16'h2222, 1'b1);
        wr(CMD_STORE_USER_ALL, 16'h0000, 1'b1);
        chk({15'h0, nvmSave}, 16'h0001);
        chk(nvmSaveImage.key, 16'h2222);
        chk(nvmSaveImage.mask, 16'h0000);
        wr(CMD_LOCK_MASK, 16'h0002, 1'b1);
        wr(CMD_UNLOCK_CODE, 16'h3333, 1'b0);
        wr(CMD_LOCK_MASK, 16'h8000, 1'b1);
        wr(CMD_LOCK_MASK, 16'h0000, 1'b0);
        chk(lockMask, 16'h8000);
        wr(CMD_UNLOCK_CODE, 16'h0000, 1'b0);
        @(negedge clock);
        nvmImage.mask = 16'h0001;
        restoreLoad = 1'b1;
        @(negedge clock);
        restoreLoad = 1'b0;
        chk(lockMask, 16'h0001);
        wr(CMD_STORE_USER_ALL, 16'h0000, 1'b0);
        boot(16'h0000, 16'hABCD);
        chk({15'h0, keyOpen}, 16'h0000);
        rd(CMD_UNLOCK_CODE, KEY_RD_FAIL0);
        wr(CMD_LOCK_MASK, 16'h0004, 1'b0);
        wr(CMD_STORE_USER_ALL, 16'h0000, 1'b0);
        wr(CMD_UNLOCK_CODE, 16'h1111, 1'b0);
        wr(CMD_UNLOCK_CODE, 16'hABCD, 1'b1);
        chk({15'h0, keyOpen}, 16'h0001);
        wr(CMD_LOCK_MASK, 16'h0004, 1'b1);
        boot(16'h0010, 16'hABCD);
        chk(lockMask, 16'h0010);
        for (int i = 0; i < 3; i++) begin
            wr(CMD_UNLOCK_CODE, 16'h1111, 1'b0);
            rd(CMD_UNLOCK_CODE, (i == 0) ? KEY_RD_FAIL1 : (i == 1) ? KEY_RD_FAIL2 : KEY_RD_BARRED);
        end
        wr(CMD_UNLOCK_CODE, 16'hABCD, 1'b0);
        chk({15'h0, keyOpen}, 16'h0000);
        @(negedge clock);
        nrst = 1'b0;
        @(negedge clock);
        chk(lockMask, MASK_RESET);
        chk({15'h0, keyOpen}, 16'h0001);
        results();
    end
endmodule
